// file: include/pms_defs.vh
// shared constants for the per-port mode sequencer
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH

// ==========================================================
// geometry
`define PMS_NPORT        4
`define PMS_DW           8
`define PMS_AW           8
`define PMS_VW           12
`define PMS_CW           3

// ==========================================================
// register offsets
`define PMS_ADDR_EVT     8'h04
`define PMS_ADDR_STAT0   8'h0C
`define PMS_ADDR_PWR     8'h10
`define PMS_ADDR_PIN     8'h11
`define PMS_ADDR_MODE    8'h12
`define PMS_ADDR_DISC    8'h13
`define PMS_ADDR_DCEN    8'h14
`define PMS_ADDR_RSTART  8'h18
`define PMS_ADDR_PWRPB   8'h19
`define PMS_ADDR_RSTPB   8'h1A

// ==========================================================
// field positions
`define PMS_RSTPB_ALL    4
`define PMS_HI_NIB       4

// ==========================================================
// mode codes, two bits per port
`define PMS_MODE_SHUT    2'h0
`define PMS_MODE_MAN     2'h1
`define PMS_MODE_SEMI    2'h2
`define PMS_MODE_AUTO    2'h3

// ==========================================================
// detect status codes
`define PMS_DET_NONE     3'h0
`define PMS_DET_SHORT    3'h1
`define PMS_DET_CAP      3'h2
`define PMS_DET_LOW      3'h3
`define PMS_DET_GOOD     3'h4
`define PMS_DET_HIGH     3'h5
`define PMS_DET_OPEN     3'h6

// ==========================================================
// probe current selection
`define PMS_PROBE_OFF    2'h0
`define PMS_PROBE_I1     2'h1
`define PMS_PROBE_I2     2'h2

// ==========================================================
// signature window, thresholds and timing
`define PMS_R_MIN_K      17
`define PMS_R_MAX_K      29
`define PMS_R_SHORT_K    1
`define PMS_OPEN_MV      4000
`define PMS_TEST_DI_UA   100
`define PMS_CLK_HZ       40000000
`define PMS_T_POINT_MS   100
`define PMS_T_REPEAT_MS  320
`define PMS_T_CLASS_MS   20
`define PMS_INIT_WAIT    3'h7

`endif

// file: logic/pms_port_mode_sequencer.v
// four-port operating-mode sequencer with signature detection
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pms_defs.vh"

// Behaviour
// - each port runs one of four modes
// - startup strap picks shutdown or automatic mode
// - host rewrites mode anytime, strap ignored
// - manual: nothing autonomous, classify only when told
// - manual: power pushbutton switches power at once
// - semiautomatic: detect, classify, power after host
// - automatic: good signature, classify, then power
// - shutdown: no detect, bits forced zero
// - inrush or overload fault removes power
// - disconnect removes power only when enabled
// - power-off pushbutton removes power in any mode
// - reset pin or global bit restores defaults
// - high strap defaults run ports unattended
// - two test currents, slope from difference
// - 17k to 29k reports code 100
// - out-of-range signatures get distinct codes
// - each point 100ms, cycle 200ms
// - excess capacitance blocks the good code
// - manual detect on restart pushbutton or detect-enable write
// - semiautomatic detection repeats every 320ms
// - good signature triggers classification, keep repeating
// - detect inhibited: shutdown, powered, or disabled
// - mode register loaded from strap level
// - pushbutton low nibble sets, high clears power
// - restart pushbutton: detect low, classify high
module pms_port_mode_sequencer #(
  parameter POINT_CYC  = `PMS_T_POINT_MS * (`PMS_CLK_HZ / 1000),
  parameter REPEAT_CYC = `PMS_T_REPEAT_MS * (`PMS_CLK_HZ / 1000),
  parameter CLASS_CYC  = `PMS_T_CLASS_MS * (`PMS_CLK_HZ / 1000),
  parameter CNT_W      = 24,
  parameter DI_UA      = `PMS_TEST_DI_UA
) (
  // clock and reset
  input  wire                          core_clk,
  input  wire                          rst_n,
  // register port
  input  wire [`PMS_AW-1:0]            reg_addr,
  input  wire [`PMS_DW-1:0]            reg_wdata,
  input  wire                          reg_wr,
  input  wire                          reg_rd,
  output reg  [`PMS_DW-1:0]            reg_rdata,
  // startup strap pin
  input  wire                          strap_auto,
  // analog front-end events, one bit per port
  input  wire [`PMS_NPORT-1:0]         fault_inrush,
  input  wire [`PMS_NPORT-1:0]         fault_overload,
  input  wire [`PMS_NPORT-1:0]         disc_dc,
  input  wire [`PMS_NPORT-1:0]         disc_ac,
  input  wire [`PMS_NPORT-1:0]         probe_cap_high,
  // converter results, packed per port
  input  wire [`PMS_NPORT*`PMS_VW-1:0] probe_volt,
  input  wire [`PMS_NPORT*`PMS_CW-1:0] class_result,
  // port drive outputs
  output wire [`PMS_NPORT-1:0]         port_power,
  output wire [2*`PMS_NPORT-1:0]       probe_pin_sel,
  output wire [`PMS_NPORT-1:0]         class_drive
);

  // ==========================================================
  // local sizes and end points
  localparam NP     = `PMS_NPORT;
  localparam VW     = `PMS_VW;
  localparam CW     = `PMS_CW;
  localparam HN     = `PMS_HI_NIB;
  localparam L_INR  = 1;
  localparam L_OVL  = L_INR + NP;
  localparam L_DDC  = L_OVL + NP;
  localparam L_DAC  = L_DDC + NP;
  localparam L_CAP  = L_DAC + NP;
  localparam L_VOLT = L_CAP + NP;
  localparam L_CLS  = L_VOLT + NP * VW;
  localparam SYN_W  = L_CLS + NP * CW;
  localparam integer END1 = POINT_CYC - 1;
  localparam integer END2 = 2 * POINT_CYC - 1;
  localparam integer BEGC = 2 * POINT_CYC;
  localparam integer ENDC = 2 * POINT_CYC + CLASS_CYC - 1;
  localparam integer ENDR = REPEAT_CYC - 1;
  localparam integer DV_LO_I = `PMS_R_MIN_K * DI_UA;
  localparam integer DV_HI_I = `PMS_R_MAX_K * DI_UA;
  localparam integer DV_SH_I = `PMS_R_SHORT_K * DI_UA;
  localparam integer OPEN_I  = `PMS_OPEN_MV;
  // per-port sequencer states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DET1 = 3'h1;
  localparam [2:0] S_DET2 = 3'h2;
  localparam [2:0] S_CLS  = 3'h3;
  localparam [2:0] S_WAIT = 3'h4;
  localparam [2:0] S_PWR  = 3'h5;

  // ==========================================================
  // input synchronisers, three flops and an agreement filter
  wire [SYN_W-1:0] syn_raw;           // all outside-domain inputs
  wire [SYN_W-1:0] syn_f;             // filtered, safe to use
  assign syn_raw = {class_result, probe_volt, probe_cap_high, disc_ac,
                    disc_dc, fault_overload, fault_inrush, strap_auto};

  genvar b;
  generate
    for (b = 0; b < SYN_W; b = b + 1) begin : g_sync
      reg s1;                         // metastable stage, read only by s2
      reg s2;
      reg s3;
      reg f;                          // accepted level
      // a change counts once the later two stages agree
      always @(posedge core_clk) begin
        s1 <= syn_raw[b];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          f <= s3;
        end
      end
      assign syn_f[b] = f;
    end
  endgenerate

  wire strap = syn_f[0];              // filtered strap level

  // ==========================================================
  // global reset: pin or reset-all pushbutton
  reg        soft_rst;                // one-cycle reset-all request
  reg  [2:0] init_cnt;                // waits for the strap filter
  reg        init_load;               // loads strap-driven defaults
  wire       rst_all = !rst_n || soft_rst;

  // decoded write strobes
  wire wr_evt    = reg_wr && (reg_addr == `PMS_ADDR_EVT);
  wire wr_mode   = reg_wr && (reg_addr == `PMS_ADDR_MODE);
  wire wr_disc   = reg_wr && (reg_addr == `PMS_ADDR_DISC);
  wire wr_dcen   = reg_wr && (reg_addr == `PMS_ADDR_DCEN);
  wire wr_rstart = reg_wr && (reg_addr == `PMS_ADDR_RSTART);
  wire wr_pwrpb  = reg_wr && (reg_addr == `PMS_ADDR_PWRPB);
  wire wr_rstpb  = reg_wr && (reg_addr == `PMS_ADDR_RSTPB);

  // reset all ports
  // soft reset runs one cycle later so the write itself completes
  always @(posedge core_clk) begin
    if (!rst_n) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_rstpb && reg_wdata[`PMS_RSTPB_ALL];
    end
  end

  // strap-dependent defaults
  // defaults are loaded after the filter has settled, never under reset
  always @(posedge core_clk) begin
    if (rst_all) begin
      init_cnt  <= 3'h0;
      init_load <= 1'b0;
    end else begin
      init_load <= (init_cnt == (`PMS_INIT_WAIT - 3'h1));
      if (init_cnt != `PMS_INIT_WAIT) begin
        init_cnt <= init_cnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // per-port state gathered for readback
  wire [2*NP-1:0] mode_w;
  wire [NP-1:0]   pwr_w;
  wire [NP-1:0]   dcen_w;
  wire [NP-1:0]   acen_w;
  wire [NP-1:0]   deten_w;
  wire [NP-1:0]   clsen_w;
  wire [NP-1:0]   devt_w;
  wire [NP-1:0]   fevt_w;
  wire [8*NP-1:0] stat_w;

  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_port
      reg [1:0]       mode;           // operating mode of this port
      reg             det_en;         // detection enable
      reg             cls_en;         // classification enable
      reg             dc_en;          // dc disconnect enable
      reg             ac_en;          // ac disconnect enable
      reg             pwr_en;         // port power enable
      reg             det_evt;        // detect cycle finished
      reg             flt_evt;        // power removed by event
      reg [2:0]       det_code;       // detect status field
      reg [CW-1:0]    cls_code;       // class status field
      reg [2:0]       state;
      reg [CNT_W-1:0] tmr;            // time since cycle start
      reg             one_shot;       // single commanded cycle
      reg [VW-1:0]    v1;             // first test point
      reg [1:0]       probe_sel;
      reg             cls_drv;
      reg [2:0]       next_code;

      wire [VW-1:0] vin    = syn_f[L_VOLT + p*VW +: VW];
      wire [CW-1:0] cls_in = syn_f[L_CLS + p*CW +: CW];
      wire [VW:0]   dv     = {1'b0, vin} - {1'b0, v1};
      wire shut    = (mode == `PMS_MODE_SHUT);
      wire man     = (mode == `PMS_MODE_MAN);
      wire autom   = (mode == `PMS_MODE_AUTO);
      wire pb_set  = wr_pwrpb && reg_wdata[p];
      wire pb_off  = wr_pwrpb && reg_wdata[p + HN];
      wire port_rst = wr_rstpb && reg_wdata[p];
      wire m_det   = (wr_rstart || wr_dcen) && reg_wdata[p];
      wire m_cls   = (wr_rstart || wr_dcen) && reg_wdata[p + HN];
      wire fault   = syn_f[L_INR + p] || syn_f[L_OVL + p];
      wire disc_hit = pwr_en && ((syn_f[L_DDC + p] && dc_en) ||
                                 (syn_f[L_DAC + p] && ac_en));
      wire clr_port = shut || pb_off || port_rst;
      wire run_ok  = one_shot || (!man && !shut && det_en);
      wire det_end = (state == S_DET2) && (tmr == END2[CNT_W-1:0]) &&
                     run_ok && !shut && !pwr_en;
      wire cls_end = (state == S_CLS) && (tmr == ENDC[CNT_W-1:0]) &&
                     !shut && !pwr_en;
      wire good    = (next_code == `PMS_DET_GOOD);
      wire auto_set = autom && !one_shot &&
                      ((det_end && good && !cls_en) || cls_end);
      // faults and enabled disconnect remove power
      wire off_req = clr_port || fault || disc_hit;
      // manual pushbutton acts regardless of detection
      wire set_req = (pb_set && !shut) || auto_set;

      always @* begin
        next_code = `PMS_DET_GOOD;
        if (vin >= OPEN_I[VW-1:0]) begin
          next_code = `PMS_DET_OPEN;
        end else if (dv[VW] || (dv < DV_SH_I[VW:0])) begin
          next_code = `PMS_DET_SHORT;
        end else if (dv < DV_LO_I[VW:0]) begin
          next_code = `PMS_DET_LOW;
        end else if (dv > DV_HI_I[VW:0]) begin
          next_code = `PMS_DET_HIGH;
        end else if (syn_f[L_CAP + p]) begin
          next_code = `PMS_DET_CAP;
        end
      end

      // configuration, power enable, events and status of this port
      always @(posedge core_clk) begin
        if (rst_all) begin
          mode     <= `PMS_MODE_SHUT;
          det_en   <= 1'b0;
          cls_en   <= 1'b0;
          dc_en    <= 1'b0;
          ac_en    <= 1'b0;
          pwr_en   <= 1'b0;
          det_evt  <= 1'b0;
          flt_evt  <= 1'b0;
          det_code <= `PMS_DET_NONE;
          cls_code <= {CW{1'b0}};
        end else begin
          if (init_load) begin
            mode <= {2{strap}};
          end else if (wr_mode) begin
            mode <= reg_wdata[2*p +: 2];
          end
          // disconnect enables, dc default follows strap
          if (init_load) begin
            dc_en <= strap;
            ac_en <= 1'b0;
          end else if (wr_disc) begin
            dc_en <= reg_wdata[p];
            ac_en <= reg_wdata[p + HN];
          end
          if (init_load) begin
            det_en <= strap;
            cls_en <= strap;
          end else if (clr_port) begin
            det_en <= 1'b0;
            cls_en <= 1'b0;
          end else if (wr_dcen) begin
            det_en <= reg_wdata[p];
            cls_en <= reg_wdata[p + HN];
          end else if (wr_rstart) begin
            if (reg_wdata[p]) begin
              det_en <= 1'b1;
            end
            if (reg_wdata[p + HN]) begin
              cls_en <= 1'b1;
            end
          end
          if (off_req) begin
            pwr_en <= 1'b0;
          end else if (set_req) begin
            pwr_en <= 1'b1;
          end
          // detect event: hardware set beats software clear
          if (clr_port) begin
            det_evt <= 1'b0;
          end else if (det_end) begin
            det_evt <= 1'b1;
          end else if (wr_evt && reg_wdata[p]) begin
            det_evt <= 1'b0;
          end
          // fault event, same precedence
          if (clr_port) begin
            flt_evt <= 1'b0;
          end else if ((fault && pwr_en) || disc_hit) begin
            flt_evt <= 1'b1;
          end else if (wr_evt && reg_wdata[p + HN]) begin
            flt_evt <= 1'b0;
          end
          // status fields
          if (clr_port) begin
            det_code <= `PMS_DET_NONE;
            cls_code <= {CW{1'b0}};
          end else begin
            if (det_end) begin
              det_code <= next_code;
            end
            if (cls_end) begin
              cls_code <= cls_in;
            end
          end
        end
      end

      // detection and classification sequencer
      always @(posedge core_clk) begin
        if (rst_all) begin
          state    <= S_IDLE;
          tmr      <= {CNT_W{1'b0}};
          one_shot <= 1'b0;
          v1       <= {VW{1'b0}};
        end else if (shut || port_rst) begin
          state    <= S_IDLE;
          one_shot <= 1'b0;
        end else if (pwr_en) begin
          // powered ports do not probe
          state    <= S_PWR;
          one_shot <= 1'b0;
        end else if (man && m_det) begin
          state    <= S_DET1;
          tmr      <= {CNT_W{1'b0}};
          one_shot <= 1'b1;
        end else begin
          case (state)
            S_IDLE: begin
              tmr <= {CNT_W{1'b0}};
              if (man && m_cls) begin
                state    <= S_CLS;
                tmr      <= BEGC[CNT_W-1:0];
                one_shot <= 1'b1;
              end else if (!man && det_en) begin
                state    <= S_DET1;
                one_shot <= 1'b0;
              end
            end
            S_DET1: begin
              // first point lasts one point time
              if (!run_ok) begin
                state <= S_IDLE;
              end else begin
                tmr <= tmr + {{(CNT_W-1){1'b0}}, 1'b1};
                if (tmr == END1[CNT_W-1:0]) begin
                  v1    <= vin;
                  state <= S_DET2;
                end
              end
            end
            S_DET2: begin
              if (!run_ok) begin
                state <= S_IDLE;
              end else begin
                tmr <= tmr + {{(CNT_W-1){1'b0}}, 1'b1};
                if (tmr == END2[CNT_W-1:0]) begin
                  if (one_shot) begin
                    state    <= S_IDLE;
                    one_shot <= 1'b0;
                  end else if (good && cls_en) begin
                    state <= S_CLS;
                  end else begin
                    state <= S_WAIT;
                  end
                end
              end
            end
            S_CLS: begin
              tmr <= tmr + {{(CNT_W-1){1'b0}}, 1'b1};
              if (tmr == ENDC[CNT_W-1:0]) begin
                if (one_shot) begin
                  state    <= S_IDLE;
                  one_shot <= 1'b0;
                end else begin
                  state <= S_WAIT;
                end
              end
            end
            S_WAIT: begin
              // cycle restarts at the repeat period
              tmr <= tmr + {{(CNT_W-1){1'b0}}, 1'b1};
              if ((tmr == ENDR[CNT_W-1:0]) || man) begin
                state <= S_IDLE;
              end
            end
            S_PWR: begin
              // power has dropped, go back to probing
              state <= S_IDLE;
            end
            default: begin
              state <= S_IDLE;
            end
          endcase
        end
      end

      // probe current and class drive, one cycle behind the state
      always @(posedge core_clk) begin
        if (rst_all) begin
          probe_sel <= `PMS_PROBE_OFF;
          cls_drv   <= 1'b0;
        end else begin
          probe_sel <= (state == S_DET1) ? `PMS_PROBE_I1 :
                       (state == S_DET2) ? `PMS_PROBE_I2 : `PMS_PROBE_OFF;
          cls_drv   <= (state == S_CLS);
        end
      end

      assign mode_w[2*p +: 2]   = mode;
      assign pwr_w[p]           = pwr_en;
      assign dcen_w[p]          = dc_en;
      assign acen_w[p]          = ac_en;
      assign deten_w[p]         = det_en;
      assign clsen_w[p]         = cls_en;
      assign devt_w[p]          = det_evt;
      assign fevt_w[p]          = flt_evt;
      assign stat_w[8*p +: 8]   = {1'b0, cls_code, 1'b0, det_code};
      assign probe_pin_sel[2*p +: 2] = probe_sel;
      assign class_drive[p]     = cls_drv;
    end
  endgenerate

  assign port_power = pwr_w;

  // ==========================================================
  // read port, data one cycle after the strobe
  wire [`PMS_AW-1:0] st_idx = reg_addr - `PMS_ADDR_STAT0;

  // pushbutton and unmapped addresses read as zero
  always @(posedge core_clk) begin
    if (rst_all) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (st_idx < NP) begin
      reg_rdata <= stat_w[st_idx*8 +: 8];
    end else begin
      case (reg_addr)
        `PMS_ADDR_EVT:  reg_rdata <= {fevt_w, devt_w};
        `PMS_ADDR_PWR:  reg_rdata <= {4'h0, pwr_w};
        `PMS_ADDR_PIN:  reg_rdata <= {7'h00, strap};
        `PMS_ADDR_MODE: reg_rdata <= mode_w;
        `PMS_ADDR_DISC: reg_rdata <= {acen_w, dcen_w};
        `PMS_ADDR_DCEN: reg_rdata <= {clsen_w, deten_w};
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// file: tb/pms_pd_model.sv
// cable-side load model answering the probe currents and class drive
`timescale 1ns/1ps
`include "pms_defs.vh"
module pms_pd_model (
  // clock
  input  wire        core_clk,
  // sequencer drive and load setup
  input  wire [7:0]  probe_pin_sel,
  input  wire [3:0]  class_drive,
  input  wire [27:0] res_k,
  input  wire [11:0] cls,
  // answers to the sequencer
  output reg  [47:0] probe_volt,
  output reg  [11:0] class_result
);
  // ====================
  // load response
  integer     p;
  integer     v;
  reg  [11:0] junk = 12'h5A3;  // undriven lines wander, never hold the last value
  always @(posedge core_clk) begin
    junk <= junk + 12'h9D5;
    for (p = 0; p < 4; p = p + 1) begin
      // two test currents: 5uA then 5uA plus the step
      v = res_k[7*p +: 7] * ((probe_pin_sel[2*p +: 2] == 2'h1) ? 5 : 5 + `PMS_TEST_DI_UA);
      if (v > 4095) v = 4095;  // converter saturates, reads as open
      probe_volt[12*p +: 12] <= (probe_pin_sel[2*p +: 2] == 2'h0) ? junk : v[11:0];
      class_result[3*p +: 3] <= class_drive[p] ? cls[3*p +: 3] : ~cls[3*p +: 3];
    end
  end
endmodule

// file: tb/pms_port_mode_sequencer_tb_top.sv
// self-checking bench for the port mode sequencer
`timescale 1ns/1ps
`define CHK(g, x) begin check_count = check_count + 1; if ((g) !== (x)) begin \
  n_fail = n_fail + 1; $display("mismatch t=%0t got %h exp %h", $time, g, x); end end
module pms_port_mode_sequencer_tb_top;
  localparam PT = 20;
  localparam RP = 70;
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [7:0]  reg_rdata;
  reg         strap_auto = 1'b0;
  reg  [3:0]  fault_inrush = 4'h0;
  reg  [3:0]  fault_overload = 4'h0;
  reg  [3:0]  disc_dc = 4'h0;
  reg  [3:0]  disc_ac = 4'h0;
  reg  [3:0]  probe_cap_high = 4'h0;
  reg  [27:0] res_k = 28'h0;      // signature per port, kohm
  reg  [11:0] cls = 12'h0;        // class shown per port
  wire [47:0] probe_volt;
  wire [11:0] class_result;
  wire [3:0]  port_power;
  wire [7:0]  probe_pin_sel;
  wire [3:0]  class_drive;
  reg  [7:0]  exp_q[$];           // expected read data, oldest first
  reg  [7:0]  e;
  reg         rd_d = 1'b0;
  reg  [31:0] rnd;
  integer     n_fail = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     i;
  integer     seed = 32'hde89;
  initial forever #12.5 core_clk = ~core_clk;
  pms_port_mode_sequencer #(.POINT_CYC(PT), .REPEAT_CYC(RP), .CLASS_CYC(10))
    pms_port_mode_sequencer_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_auto(strap_auto), .fault_inrush(fault_inrush), .fault_overload(fault_overload),
    .disc_dc(disc_dc), .disc_ac(disc_ac), .probe_cap_high(probe_cap_high),
    .probe_volt(probe_volt), .class_result(class_result), .port_power(port_power),
    .probe_pin_sel(probe_pin_sel), .class_drive(class_drive));
  pms_pd_model pms_pd_model_i (.core_clk(core_clk), .probe_pin_sel(probe_pin_sel),
    .class_drive(class_drive), .res_k(res_k), .cls(cls), .probe_volt(probe_volt),
    .class_result(class_result));
  // ====================
  // bus tasks, monitor, verdict
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] x);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge core_clk);
      reg_rd <= 1'b0;
    end
  endtask
  task give_verdict;
    begin
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // read data stands only the cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    cyc = cyc + 1;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  // ====================
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rnd = $random(seed);
    cls <= rnd[11:0];
    rd(8'h12, 8'h00);
    wr(8'h12, 8'h55);
    wr(8'h19, 8'h01);
    rd(8'h10, 8'h01);
    wr(8'h19, 8'h00);
    rd(8'h10, 8'h01);
    wr(8'h19, 8'h10);
    rd(8'h10, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h19, 8'h01 << i);
      rd(8'h10, 8'h01 << i);
      fault_inrush <= {3'h0, i == 0};
      fault_overload <= {2'h0, i == 1, 1'b0};
      repeat (10) @(posedge core_clk);
      rd(8'h10, 8'h00);
      fault_inrush <= 4'h0;
      fault_overload <= 4'h0;
      repeat (8) @(posedge core_clk);
    end
    wr(8'h19, 8'h01);
    disc_dc <= 4'h1;
    repeat (10) @(posedge core_clk);
    rd(8'h10, 8'h01);
    wr(8'h13, 8'h01);
    repeat (8) @(posedge core_clk);
    rd(8'h10, 8'h00);
    disc_dc <= 4'h0;
    disc_ac <= 4'h1;
    repeat (8) @(posedge core_clk);
    wr(8'h19, 8'h01);
    repeat (8) @(posedge core_clk);
    rd(8'h10, 8'h01);
    wr(8'h13, 8'h10);
    repeat (8) @(posedge core_clk);
    rd(8'h10, 8'h00);
    disc_ac <= 4'h0;
    res_k <= {7'd25, 7'd35, 7'd10, 7'd25};
    probe_cap_high <= 4'h8;
    repeat (8) @(posedge core_clk);
    wr(8'h18, 8'h0F);
    repeat (2 * PT + 6) @(posedge core_clk);
    rd(8'h0C, 8'h04);
    rd(8'h0D, 8'h03);
    rd(8'h0E, 8'h05);
    rd(8'h0F, 8'h02);
    rd(8'h04, 8'h3F);
    rd(8'h18, 8'h00);
    wr(8'h18, 8'h40);
    repeat (14) @(posedge core_clk);
    rd(8'h0E, {1'b0, cls[8:6], 4'h5});
    res_k <= {7'd25, 7'd25, 7'd60, 7'd0};
    probe_cap_high <= 4'h0;
    wr(8'h18, 8'h03);
    repeat (2 * PT + 6) @(posedge core_clk);
    rd(8'h0C, 8'h01);
    rd(8'h0D, 8'h06);
    res_k <= {7'd25, 7'd25, 7'd60, 7'd25};
    wr(8'h12, 8'h56);
    wr(8'h14, 8'h11);
    repeat (3 * RP) @(posedge core_clk);
    rd(8'h0C, {1'b0, cls[2:0], 4'h4});
    rd(8'h10, 8'h00);
    wr(8'h19, 8'h01);
    rd(8'h10, 8'h01);
    wr(8'h19, 8'h10);
    wr(8'h12, 8'h57);
    wr(8'h14, 8'h11);
    repeat (3 * RP) @(posedge core_clk);
    rd(8'h10, 8'h01);
    wr(8'h12, 8'h54);
    rd(8'h10, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h14, 8'h00);
    strap_auto <= 1'b1;
    repeat (8) @(posedge core_clk);
    wr(8'h1A, 8'h10);
    repeat (12) @(posedge core_clk);
    rd(8'h12, 8'hFF);
    rd(8'h14, 8'hFF);
    rd(8'h13, 8'h0F);
    rd(8'h10, 8'h00);
    repeat (3 * RP) @(posedge core_clk);
    rd(8'h10, 8'h0D);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(8'h10, 8'h00);
    wr(8'h12, 8'h00);
    rd(8'h12, 8'h00);
    repeat (4) @(posedge core_clk);
    give_verdict;
  end
endmodule
bind pms_port_mode_sequencer pms_seq_sva #(.POINT_CYC(POINT_CYC)) pms_seq_sva_i (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_inrush(fault_inrush),
  .fault_overload(fault_overload), .port_power(port_power),
  .probe_pin_sel(probe_pin_sel), .class_drive(class_drive));

// file: tb/pms_seq_sva.sv
// port-level assertions for the mode sequencer
`timescale 1ns/1ps
module pms_seq_sva #(
  parameter POINT_CYC = 20
) (
  // clock, reset and register port
  input wire       core_clk,
  input wire       rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // events and drive
  input wire [3:0] fault_inrush,
  input wire [3:0] fault_overload,
  input wire [3:0] port_power,
  input wire [7:0] probe_pin_sel,
  input wire [3:0] class_drive
);
  // ====================
  // helpers
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [1:0]  sel0 = probe_pin_sel[1:0];  // port 0 probe current
  reg  [23:0] run1;                        // cycles spent on first current
  always @(posedge core_clk) begin
    run1 <= (!rst_n || sel0 != 2'h1) ? 24'h0 : run1 + 24'h1;
  end
  sequence s_pt_step;
    sel0 == 2'h1 ##1 sel0 == 2'h2;
  endsequence
  a_reset_off: assert property (disable iff (1'b0) !rst_n |=> port_power == 4'h0
    && probe_pin_sel == 8'h00 && class_drive == 4'h0) else $error("outputs live in reset");
  a_pb_rdzero: assert property (reg_rd && reg_addr >= 8'h18 && reg_addr <= 8'h1A
    |=> reg_rdata == 8'h00) else $error("pushbutton read not zero");
  a_inrush_off: assert property (fault_inrush[0] [*8] |-> !port_power[0])
    else $error("inrush fault kept power");
  a_ovl_off: assert property (fault_overload[1] [*8] |-> !port_power[1])
    else $error("overload fault kept power");
  a_clr_pb: assert property (reg_wr && reg_addr == 8'h19
    |=> (port_power & $past(reg_wdata[7:4])) == 4'h0) else $error("power-off ignored");
  a_probe_pwr: assert property (port_power[0] [*3] |-> sel0 == 2'h0)
    else $error("probing a powered port");
  a_pt_len: assert property (s_pt_step |-> run1 == POINT_CYC)
    else $error("first point length wrong");
  a_cur_order: assert property (sel0 == 2'h0 |=> sel0 != 2'h2)
    else $error("second current without first");
endmodule
